// File: core/supply_pin_fuse_programming.sv
`timescale 1ns/1ps
`default_nettype none
module supply_pin_fuse_programming (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic level_mid_pulse,
	input wire logic level_high_pulse,
	input wire logic [fuse_prog_pkg::MAG_W-1:0] fuse_sense_mag,
	input wire logic [fuse_prog_pkg::OUT_W-1:0] fuse_sense_out,
	output logic [fuse_prog_pkg::MAG_W-1:0] threshold_magnitude_field,
	output logic threshold_polarity_bit,
	output logic output_polarity,
	output logic [1:0] fall_select,
	output logic device_locked,
	output logic mode_trial,
	output logic mode_burn,
	output logic key_refused,
	output logic read_valid,
	output logic read_bit,
	output logic burn_strobe,
	output logic burn_reg_out,
	output logic [2:0] burn_bit_index
);
	import fuse_prog_pkg::*;

	// ========================================
	// state
	// ========================================
	typedef struct packed {
		logic [1:0] mid_sync;
		logic [1:0] high_sync;
		level_type peak;
		logic [WIDTH_CNT_W-1:0] width;
		prog_state_type state;
		logic [2:0] key;
		logic [MAG_W-1:0] code;
		logic [3:0] mid_run;
		logic [2:0] bit_idx;
		logic burned;
		logic burn_pulse;
		logic rd_valid;
		logic rd_bit;
		logic [MAG_W-1:0] mag_q;
		logic tpol_q;
		logic [OUT_W-1:0] out_q;
	} prog_type;

	prog_type r;
	prog_type n;
	level_type level_now;
	logic pulse_done;
	logic pulse_is_high;
	logic [7:0] sense_sel;
	logic is_virtual;
	logic trying;

	// comparators sampled through two flops; only the second stage is read
	always_comb begin
		if (r.high_sync[1]) begin
			level_now = LVL_HIGH;
		end else if (r.mid_sync[1]) begin
			level_now = LVL_MID;
		end else begin
			level_now = LVL_LOW;
		end
	end

	// short spikes never reach the decoder: too brief a pulse is dropped
	assign pulse_done = (level_now == LVL_LOW) && (r.peak != LVL_LOW)
		&& (r.width >= SELECT_PULSE_CYC);
	assign pulse_is_high = (r.peak == LVL_HIGH);
	assign is_virtual = (r.key <= KEY_NEG_DOWN);
	assign trying = (r.state == ST_TRY);
	// fuse sense widened to one byte so either register indexes alike
	assign sense_sel = (r.key == KEY_MAG) ? fuse_sense_mag : {3'h0, fuse_sense_out};

	// ========================================
	// next state
	// ========================================
	always_comb begin
		n = r;
		n.mid_sync = {r.mid_sync[0], level_mid_pulse};
		n.high_sync = {r.high_sync[0], level_high_pulse};
		n.burn_pulse = 1'b0;

		// width and peak level of the pulse in progress
		if (level_now != LVL_LOW) begin
			if (r.width != {WIDTH_CNT_W{1'b1}}) begin
				n.width = r.width + WIDTH_CNT_W'(1);
			end
			if (level_now == LVL_HIGH) begin
				n.peak = LVL_HIGH;
			end else if (r.peak == LVL_LOW) begin
				n.peak = LVL_MID;
			end
			// fuse opens once the high pulse has lasted the burn width
			if ((r.state == ST_BURN) && (level_now == LVL_HIGH) && !r.burned
				&& (r.width == BURN_PULSE_CYC - WIDTH_CNT_W'(1))) begin
				n.burn_pulse = 1'b1;
				n.burned = 1'b1;
			end
		end else begin
			n.peak = LVL_LOW;
			n.width = '0;
		end

		// decode on the fall back to low
		if (pulse_done) begin
			case (r.state)
				ST_IDLE: begin
					n.state = pulse_is_high ? ST_GOT_HIGH : ST_DEAD;
				end
				ST_GOT_HIGH: begin
					n.state = pulse_is_high ? ST_DEAD : ST_KEY;
					n.key = '0;
				end
				ST_KEY: begin
					if (!pulse_is_high) begin
						if (r.key == 3'h7) begin
							n.state = ST_DEAD;
						end else begin
							n.key = r.key + 3'h1;
						end
					end else if (fuse_sense_out[LOCK_BIT] || (r.key > KEY_OUT)) begin
						n.state = ST_DEAD;
					end else begin
						n.state = ST_TRY;
						n.code = TRY_START_CODE;
						n.mid_run = '0;
					end
				end
				ST_TRY: begin
					if (!pulse_is_high) begin
						if (r.mid_run != 4'hf) begin
							n.mid_run = r.mid_run + 4'h1;
						end
						if (is_virtual) begin
							n.code = r.code + 8'h01;
						end else if (r.code != ((r.key == KEY_MAG) ? MAG_MAX : OUT_TRY_MAX)) begin
							n.code = r.code + 8'h01;
						end
					end else if (!is_virtual && (r.mid_run == MODE_KEY_MIDS)) begin
						// mode key seen: trial value is dropped, address starts at bit 0
						n.state = ST_BURN;
						n.code = '0;
						n.bit_idx = '0;
						n.rd_valid = 1'b0;
					end else begin
						n.state = ST_DEAD;
					end
				end
				ST_BURN: begin
					if (r.burned) begin
						n.state = ST_DONE;
					end else if (!pulse_is_high) begin
						n.rd_valid = 1'b0;
						if (r.bit_idx == ((r.key == KEY_MAG) ? MAG_TOP_BIT : OUT_TOP_BIT)) begin
							n.state = ST_DEAD;
						end else begin
							n.bit_idx = r.bit_idx + 3'h1;
						end
					end else begin
						// short high pulse in this mode reads the addressed fuse
						n.rd_valid = 1'b1;
						n.rd_bit = sense_sel[r.bit_idx];
					end
				end
				ST_DONE: begin
					n.state = ST_DONE;
				end
				ST_DEAD: begin
					n.state = ST_DEAD;
				end
				default: begin
					n.state = ST_DEAD;
				end
			endcase
		end

		// applied values: opened fuses always win, trial bits only add on top
		n.mag_q = fuse_sense_mag;
		if (trying && is_virtual) begin
			// down registers walk the magnitude from the top toward zero
			n.mag_q = fuse_sense_mag | (r.key[0] ? ~r.code : r.code);
		end else if (trying && (r.key == KEY_MAG)) begin
			n.mag_q = fuse_sense_mag | r.code;
		end
		n.tpol_q = fuse_sense_out[TPOL_BIT] | (trying && is_virtual && r.key[1]);
		// the lock bit is never applied by trial, only by an opened fuse
		n.out_q = fuse_sense_out;
		if (trying && (r.key == KEY_OUT)) begin
			n.out_q = fuse_sense_out | (r.code[OUT_W-1:0] & OUT_TRY_MASK);
		end
	end

	// ========================================
	// registers; reset stands for supply power-up
	// ========================================
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	// ========================================
	// outputs
	// ========================================
	assign threshold_magnitude_field = r.mag_q;
	assign threshold_polarity_bit = r.tpol_q;
	assign output_polarity = r.out_q[POL_BIT];
	assign fall_select = r.out_q[FALL_LSB+1:FALL_LSB];
	assign device_locked = r.out_q[LOCK_BIT];
	assign mode_trial = trying;
	assign mode_burn = (r.state == ST_BURN);
	assign key_refused = (r.state == ST_DEAD);
	assign read_valid = r.rd_valid;
	assign read_bit = r.rd_bit;
	assign burn_strobe = r.burn_pulse;
	assign burn_reg_out = (r.key == KEY_OUT);
	assign burn_bit_index = r.bit_idx;
endmodule // supply_pin_fuse_programming
`default_nettype wire

// File: dv/fuse_prog_properties.sv
`timescale 1ns/1ps
`default_nettype none
module fuse_prog_properties (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic level_mid_pulse,
	input wire logic [fuse_prog_pkg::OUT_W-1:0] fuse_sense_out,
	input wire logic device_locked,
	input wire logic mode_trial,
	input wire logic mode_burn,
	input wire logic key_refused,
	input wire logic burn_strobe
);
	import fuse_prog_pkg::*;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	// ========================================
	// mode, lock and strobe relations
	// ========================================
	lock_follows_a: assert property (!$past(rst) |-> device_locked == $past(fuse_sense_out[LOCK_BIT]))
		else $error("lock flag does not follow its fuse");
	lock_blocks_a: assert property ($rose(mode_trial || mode_burn) |-> !device_locked)
		else $error("mode entered while locked");
	strobe_single_a: assert property (burn_strobe |=> !burn_strobe)
		else $error("burn strobe longer than one cycle");
	strobe_burn_a: assert property (burn_strobe |-> mode_burn)
		else $error("burn strobe outside burn mode");
	modes_apart_a: assert property (!(mode_trial && mode_burn))
		else $error("trial and burn both set");
	refuse_sticks_a: assert property (key_refused |=> key_refused)
		else $error("refusal dropped without reset");
	refuse_idle_a: assert property (key_refused |-> !mode_trial && !mode_burn)
		else $error("mode active while refused");
	// a level still up cannot have been decoded yet
	pulse_hold_a: assert property (level_mid_pulse [*8] |-> $stable(mode_trial) && $stable(key_refused))
		else $error("state moved during a pulse");
	cover property ($rose(mode_trial));
	cover property ($rose(mode_burn));
	cover property (burn_strobe);
endmodule // fuse_prog_properties
bind supply_pin_fuse_programming fuse_prog_properties u_fuse_prog_properties (
	.clk_sys(clk_sys), .rst(rst), .level_mid_pulse(level_mid_pulse),
	.fuse_sense_out(fuse_sense_out), .device_locked(device_locked), .mode_trial(mode_trial),
	.mode_burn(mode_burn), .key_refused(key_refused), .burn_strobe(burn_strobe)
);
`default_nettype wire

// File: dv/supply_programmer_model.sv
`timescale 1ns/1ps
`default_nettype none
module supply_programmer_model (
	input wire logic clk_sys,
	input wire logic burn_strobe,
	input wire logic burn_reg_out,
	input wire logic [2:0] burn_bit_index,
	output logic level_mid_pulse,
	output logic level_high_pulse,
	output logic [fuse_prog_pkg::MAG_W-1:0] fuse_sense_mag,
	output logic [fuse_prog_pkg::OUT_W-1:0] fuse_sense_out
);
	import fuse_prog_pkg::*;
	localparam int GAP = 20;
	// ========================================
	// fuses: open only, reset never reaches them
	// ========================================
	initial begin
		fuse_sense_mag = 8'h00;
		fuse_sense_out = 5'h00;
		level_mid_pulse = 1'b0;
		level_high_pulse = 1'b0;
	end
	always @(posedge clk_sys) begin
		if (burn_strobe && !burn_reg_out) begin
			fuse_sense_mag[burn_bit_index] <= 1'b1;
		end
		if (burn_strobe && burn_reg_out) begin
			fuse_sense_out[burn_bit_index] <= 1'b1;
		end
	end
	// ========================================
	// pulse trains, changed on falling edges
	// ========================================
	// levels step at once, steeper than any slew bound
	task automatic send(input logic hi, input int cyc);
		level_mid_pulse = 1'b1;
		level_high_pulse = hi;
		repeat (cyc) @(negedge clk_sys);
		level_mid_pulse = 1'b0;
		level_high_pulse = 1'b0;
		repeat (GAP) @(negedge clk_sys);
	endtask
	task automatic key(input int k);
		send(1'b1, 420);
		send(1'b0, 420);
		repeat (k) send(1'b0, 420);
		send(1'b1, 420);
	endtask
	task automatic to_burn(input int bit_n);
		repeat (11) send(1'b0, 420);
		send(1'b1, 420);
		repeat (bit_n) send(1'b0, 420);
	endtask
endmodule // supply_programmer_model
`default_nettype wire

// File: dv/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import fuse_prog_pkg::*;
	logic clk_sys;
	logic rst = 1'b1;
	logic level_mid_pulse, level_high_pulse, threshold_polarity_bit, device_locked;
	logic mode_trial, mode_burn, key_refused, read_valid, read_bit, burn_strobe, burn_reg_out;
	logic [7:0] fuse_sense_mag, threshold_magnitude_field;
	logic [4:0] fuse_sense_out;
	logic [2:0] burn_bit_index;
	logic output_polarity;
	logic [1:0] fall_select;
	logic [3:0] strobe_seen = 4'hf;
	int err_count = 0;
	int checked = 0;
	int cycles = 0;
	supply_pin_fuse_programming u_supply_pin_fuse_programming (.clk_sys(clk_sys), .rst(rst),
		.level_mid_pulse(level_mid_pulse), .level_high_pulse(level_high_pulse),
		.fuse_sense_mag(fuse_sense_mag), .fuse_sense_out(fuse_sense_out),
		.threshold_magnitude_field(threshold_magnitude_field),
		.threshold_polarity_bit(threshold_polarity_bit), .output_polarity(output_polarity),
		.fall_select(fall_select),
		.device_locked(device_locked), .mode_trial(mode_trial), .mode_burn(mode_burn),
		.key_refused(key_refused), .read_valid(read_valid), .read_bit(read_bit),
		.burn_strobe(burn_strobe), .burn_reg_out(burn_reg_out), .burn_bit_index(burn_bit_index));
	supply_programmer_model u_supply_programmer_model (.clk_sys(clk_sys),
		.burn_strobe(burn_strobe), .burn_reg_out(burn_reg_out), .burn_bit_index(burn_bit_index),
		.level_mid_pulse(level_mid_pulse), .level_high_pulse(level_high_pulse),
		.fuse_sense_mag(fuse_sense_mag), .fuse_sense_out(fuse_sense_out));
	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end
	// strobe lasts one cycle, so latch where it pointed
	always @(posedge clk_sys) begin
		cycles++;
		if (burn_strobe === 1'b1) strobe_seen <= {burn_reg_out, burn_bit_index};
		if (cycles == 80000) begin
			err_count++;
			tally_and_finish();
		end
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic power_cycle();
		rst = 1'b1;
		repeat (3) @(negedge clk_sys);
		rst = 1'b0;
		repeat (3) @(negedge clk_sys);
	endtask
	task automatic t_trial();
		power_cycle();
		u_supply_programmer_model.key(0);
		chk(8'(mode_trial), 8'h01);
		chk(threshold_magnitude_field, TRY_START_CODE);
		u_supply_programmer_model.send(1'b0, 420);
		chk(threshold_magnitude_field, 8'h02);
		power_cycle();
		chk(threshold_magnitude_field, 8'h00);
		u_supply_programmer_model.key(3);
		chk(threshold_magnitude_field, 8'hfe);
		chk(8'(threshold_polarity_bit), 8'h01);
		// output register trial: fall and polarity share one code
		power_cycle();
		u_supply_programmer_model.key(5);
		chk({output_polarity, fall_select}, 8'h01);
		repeat (6) u_supply_programmer_model.send(1'b0, 420);
		chk({output_polarity, fall_select}, 8'h07);
		$display("test trial done");
	endtask
	task automatic t_burn();
		power_cycle();
		u_supply_programmer_model.key(4);
		u_supply_programmer_model.to_burn(2);
		chk(8'(mode_burn), 8'h01);
		u_supply_programmer_model.send(1'b1, 420);
		chk({read_valid, read_bit}, 8'h02);
		u_supply_programmer_model.send(1'b1, 2100);
		chk(8'(strobe_seen), 8'h02);
		power_cycle();
		chk(threshold_magnitude_field, 8'h04);
		u_supply_programmer_model.key(4);
		u_supply_programmer_model.to_burn(2);
		u_supply_programmer_model.send(1'b1, 420);
		chk({read_valid, read_bit}, 8'h03);
		$display("test burn done");
	endtask
	task automatic t_lock();
		power_cycle();
		u_supply_programmer_model.key(6);
		chk(8'(key_refused), 8'h01);
		chk(threshold_magnitude_field, 8'h04);
		power_cycle();
		u_supply_programmer_model.key(5);
		u_supply_programmer_model.to_burn(4);
		u_supply_programmer_model.send(1'b1, 2100);
		chk(8'(strobe_seen), 8'h0c);
		power_cycle();
		chk(8'(device_locked), 8'h01);
		u_supply_programmer_model.key(0);
		chk({key_refused, mode_trial}, 8'h02);
		$display("test lock done");
	endtask
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", checked, err_count);
		if (err_count == 0 && checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	initial begin
		@(negedge clk_sys);
		t_trial();
		t_burn();
		t_lock();
		tally_and_finish();
	end
endmodule // tb_top
`default_nettype wire

// File: inc/fuse_prog_pkg.sv
`default_nettype none
package fuse_prog_pkg;
	// ========================================
	// clock and pulse timing
	// ========================================
	localparam int CLK_PERIOD_NS = 50;
	// least width of a key or code pulse
	localparam int SELECT_PULSE_WIDTH_NS = 20000;
	// least width of a fuse-opening pulse
	localparam int BURN_PULSE_WIDTH_NS = 100000;
	localparam int WIDTH_CNT_W = 12;
	// least times round up to whole cycles
	localparam logic [WIDTH_CNT_W-1:0] SELECT_PULSE_CYC =
		WIDTH_CNT_W'((SELECT_PULSE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [WIDTH_CNT_W-1:0] BURN_PULSE_CYC =
		WIDTH_CNT_W'((BURN_PULSE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	// ========================================
	// parameter fields
	// ========================================
	localparam int MAG_W = 8;
	localparam int OUT_W = 5;
	localparam int FALL_LSB = 0;
	localparam int POL_BIT = 2;
	localparam int TPOL_BIT = 3;
	localparam int LOCK_BIT = 4;
	localparam logic [MAG_W-1:0] MAG_MAX = 8'hff;
	localparam logic [MAG_W-1:0] OUT_TRY_MAX = 8'h1f;
	localparam logic [OUT_W-1:0] OUT_TRY_MASK = 5'h0f;
	localparam logic [2:0] MAG_TOP_BIT = 3'h7;
	localparam logic [2:0] OUT_TOP_BIT = 3'h4;

	// ========================================
	// keys: number of mid pulses between the opening high-mid pair and the closing high
	// ========================================
	localparam logic [2:0] KEY_POS_UP = 3'h0;
	localparam logic [2:0] KEY_POS_DOWN = 3'h1;
	localparam logic [2:0] KEY_NEG_UP = 3'h2;
	localparam logic [2:0] KEY_NEG_DOWN = 3'h3;
	localparam logic [2:0] KEY_MAG = 3'h4;
	localparam logic [2:0] KEY_OUT = 3'h5;
	localparam logic [3:0] MODE_KEY_MIDS = 4'hb;
	localparam logic [7:0] TRY_START_CODE = 8'h01;

	typedef enum logic [1:0] {
		LVL_LOW = 2'b00,
		LVL_MID = 2'b01,
		LVL_HIGH = 2'b11
	} level_type;

	// gray along idle -> high -> high/mid -> trial -> burn -> done
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_GOT_HIGH = 3'b001,
		ST_KEY = 3'b011,
		ST_TRY = 3'b010,
		ST_BURN = 3'b110,
		ST_DONE = 3'b111,
		ST_DEAD = 3'b101
	} prog_state_type;
endpackage
`default_nettype wire
